// *** rtl/sms_cfg.svh ***
// Constants for the serial master select-control block.
// Assumes a 100 MHz system clock; included by its bare name.
`ifndef SMS_CFG_SVH
`define SMS_CFG_SVH

`define SMS_DATA_W        8
`define SMS_FIFO_DEPTH    4
`define SMS_LAST_BIT      3'h7
`define SMS_BIT_ZERO      3'h0
`define SMS_CLK_NS        10
`define SMS_HALF_BIT_NS   50
`define SMS_MASTER_RST    1'b0
`define SMS_TXE_RST       1'b1
`define SMS_FLAG_RST      1'b0
`define SMS_BYTE_RST      8'h00
`define SMS_BYTE_CLOCKS   4'h8

`endif

// *** rtl/sms_pkg.sv ***
// Types shared by the serial master select-control block.
// Assumes nothing of its surroundings.
package sms_pkg;

	typedef enum {SMS_IDLE, SMS_LEAD, SMS_HIGH, SMS_LOW} sms_state_t;

	typedef enum logic [1:0] {SMS_QUASI, SMS_PUSH_PULL, SMS_INPUT_ONLY, SMS_OPEN_DRAIN}
		sms_port_mode_t;

	typedef struct packed {
		logic out;
		logic oe;
	} sms_pin_t;

endpackage

// *** rtl/sms_master_select.sv ***
// Serial master select control: select handling, mode fault, pin override, tx path.
// Assumes pins arrive asynchronously and software strobes are one-cycle pulses on sys_clk.
`timescale 1ns/100ps
`include "sms_cfg.svh"

module sms_tx_fifo #(
	parameter int WIDTH = `SMS_DATA_W,
	parameter int DEPTH = `SMS_FIFO_DEPTH
) (
	input  wire logic             sys_clk,   // System clock
	input  wire logic             reset,     // Synchronous reset
	input  wire logic             inValid,   // Write request
	output logic                  inReady,   // Space available
	input  wire logic [WIDTH-1:0] inData,    // Write data
	output logic                  outValid,  // Word available
	input  wire logic             outReady,  // Consumer takes word
	output logic      [WIDTH-1:0] outData    // Head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr;
	logic [AW:0]      rdPtr;
	wire              isEmpty = (wrPtr == rdPtr);
	wire              isFull  = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
	wire              doWrite = inValid && !isFull;
	wire              doRead  = outReady && !isEmpty;
	assign inReady  = !isFull;
	assign outValid = !isEmpty;
	assign outData  = mem[rdPtr[AW-1:0]];
	always_ff @(posedge sys_clk)
	begin
		if (doWrite)
			mem[wrPtr[AW-1:0]] <= inData;
	end
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
		end
		else
		begin
			wrPtr <= wrPtr + (AW+1)'(doWrite);
			rdPtr <= rdPtr + (AW+1)'(doRead);
		end
	end
endmodule // sms_tx_fifo

// How it works
// - Unselected slave leaves its data-out tristated
// - Master with select disabled ignores select pin
// - Select low in master drops to slave
// - That event sets mode fault, may interrupt
// - Clearing select-disable keeps mode fault flag
// - Master bit returns only by software write
// - Select-ignore makes select pin fully ignored
// - Slave with phase and disable always selected
// - Enabled block forces clock and data pin directions from role
// - Master drives clock and data-out; slave receives
// - Quasi/open-drain data-out released between transfers
// - Push-pull data-out tristated between transfers
// - Data write queues byte; load sets empty flag
// - First clock waits for next bit slot
// - Byte end sets done flag, captures byte
// - Empty flag cleared by software or write
// - Queued byte starts next transfer at end
// - Empty interrupt needs enable and enhanced mode
// - Fault clears after status read, control write
// - Master makes exactly eight clocks per byte
module sms_master_select #(
	parameter int HALF_BIT_NS = `SMS_HALF_BIT_NS
) (
	input  wire logic                        sys_clk,          // System clock, 100 MHz
	input  wire logic                        reset,            // Synchronous, active high
	input  wire logic                        serialEnable,     // Block enable, soft reset when 0
	input  wire logic                        ctrlWrite,        // Control register write strobe
	input  wire logic                        ctrlMasterIn,     // Master bit value on that write
	input  wire logic                        selectDisable,    // Select-disable control bit
	input  wire logic                        selectIgnore,     // Select-ignore control bit
	input  wire logic                        clockPhase,       // Clock phase control bit
	input  wire logic                        intEnable,        // Serial interrupt enable
	input  wire logic                        enhancedMode,     // Enhanced mode bit
	input  wire sms_pkg::sms_port_mode_t     portMode,         // Pin driver configuration
	input  wire logic                        statusRead,       // Status register read strobe
	input  wire logic                        txEmptyClear,     // Software clear of empty flag
	input  wire logic                        doneClear,        // Software clear of done flag
	input  wire logic                        txValid,          // Data register write
	output logic                             txReady,          // Transmit buffer has room
	input  wire logic [`SMS_DATA_W-1:0]      txData,           // Data register write value
	output logic                             masterRole,       // Master bit
	output logic                             modeFault,        // Mode fault flag
	output logic                             transferDone,     // Transfer done flag
	output logic                             txBufferEmpty,    // Transmit buffer empty flag
	output logic [`SMS_DATA_W-1:0]           rxData,           // Receive buffer
	output logic                             irq,              // Serial interrupt request
	input  wire sms_pkg::sms_pin_t           portSck,          // Port control of clock pin
	input  wire sms_pkg::sms_pin_t           portMosi,         // Port control of data-out pin
	input  wire sms_pkg::sms_pin_t           portMiso,         // Port control of data-in pin
	input  wire sms_pkg::sms_pin_t           portSelect,       // Port control of select pin
	input  wire logic                        sckIn,            // Clock pin level
	output logic                             sckOut,           // Clock pin drive value
	output logic                             sckOe,            // Clock pin drive enable
	input  wire logic                        mosiIn,           // Data-out pin level
	output logic                             mosiOut,          // Data-out pin drive value
	output logic                             mosiOe,           // Data-out pin drive enable
	input  wire logic                        misoIn,           // Data-in pin level
	output logic                             misoOut,          // Data-in pin drive value
	output logic                             misoOe,           // Data-in pin drive enable
	input  wire logic                        selectInN,        // Select pin level, active low
	output logic                             selectOut,        // Select pin drive value
	output logic                             selectOe          // Select pin drive enable
);
	localparam int HALF_CYCLES = (HALF_BIT_NS + `SMS_CLK_NS - 1) / `SMS_CLK_NS;
	localparam int DW = $clog2(HALF_CYCLES + 1);
	// Two-stage synchronisers: bit 0 clock, 1 data-out, 2 data-in, 3 select
	logic [3:0] syncA;
	logic [3:0] syncB;
	wire  [3:0] pinRaw = {selectInN, misoIn, mosiIn, sckIn};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			always_ff @(posedge sys_clk)
			begin
				syncA[gi] <= pinRaw[gi];
				syncB[gi] <= syncA[gi];
			end
		end
	endgenerate
	logic                   sckPrev;
	logic [DW-1:0]          divCnt;
	sms_pkg::sms_state_t    state;
	sms_pkg::sms_state_t    next_state;
	logic [2:0]             bitCnt;
	logic [`SMS_DATA_W-1:0] shiftReg;
	logic [`SMS_DATA_W-1:0] next_shift;
	logic                   sampleBit;
	logic                   shiftFull;
	logic                   faultArmed;
	logic                   fifoValid;
	logic [`SMS_DATA_W-1:0] fifoData;

	wire sckS    = syncB[0];
	wire mosiS   = syncB[1];
	wire misoS   = syncB[2];
	wire selectS = syncB[3];
	wire tick    = (divCnt == '0);

	// Permanent selection frees the select pin for general use
	wire selected     = selectIgnore || (clockPhase && selectDisable) || !selectS;
	wire faultEvent   = serialEnable && masterRole && !selectIgnore && !selectDisable
		&& !selectS;
	wire slaveActive  = serialEnable && !masterRole && selected;
	wire slaveRise    = slaveActive && sckS && !sckPrev;
	wire slaveFall    = slaveActive && !sckS && sckPrev;
	wire masterRise   = tick && ((state == sms_pkg::SMS_LEAD) || (state == sms_pkg::SMS_LOW));
	wire masterFall   = tick && (state == sms_pkg::SMS_HIGH);
	wire shiftNow     = masterFall || slaveFall;
	wire byteDone     = shiftNow && (bitCnt == `SMS_LAST_BIT);
	wire engineIdle   = (state == sms_pkg::SMS_IDLE) && (bitCnt == `SMS_BIT_ZERO);
	wire loadShift    = serialEnable && fifoValid && !shiftFull && engineIdle;
	wire busy         = (state != sms_pkg::SMS_IDLE);
	wire txWrite      = txValid && txReady;
	wire drivesPins   = (portMode != sms_pkg::SMS_INPUT_ONLY);
	wire openDrain    = (portMode == sms_pkg::SMS_OPEN_DRAIN);

	sms_tx_fifo #(
		.WIDTH(`SMS_DATA_W),
		.DEPTH(`SMS_FIFO_DEPTH)
	) u_tx_fifo (
		.sys_clk (sys_clk),
		.reset   (reset || !serialEnable),
		.inValid (txValid),
		.inReady (txReady),
		.inData  (txData),
		.outValid(fifoValid),
		.outReady(loadShift),
		.outData (fifoData)
	);

	// Free-running rate generator: a new transfer waits for the next slot
	always_ff @(posedge sys_clk)
	begin
		if (reset || tick)
			divCnt <= DW'(HALF_CYCLES - 1);
		else
			divCnt <= divCnt - DW'(1);
	end

	always_comb
	begin
		next_state = state;
		case (state)
			sms_pkg::SMS_IDLE:
				if (masterRole && shiftFull && serialEnable)
					next_state = sms_pkg::SMS_LEAD;
			sms_pkg::SMS_LEAD:
				if (tick)
					next_state = sms_pkg::SMS_HIGH;
			sms_pkg::SMS_HIGH:
				if (tick)
					next_state = byteDone ? sms_pkg::SMS_IDLE : sms_pkg::SMS_LOW;
			sms_pkg::SMS_LOW:
				if (tick)
					next_state = sms_pkg::SMS_HIGH;
			default:
				next_state = sms_pkg::SMS_IDLE;
		endcase
		if (faultEvent || !serialEnable || !masterRole)
			next_state = sms_pkg::SMS_IDLE;
	end

	assign next_shift = loadShift ? fifoData :
		shiftNow ? {shiftReg[`SMS_DATA_W-2:0], sampleBit} : shiftReg;

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			state     <= sms_pkg::SMS_IDLE;
			bitCnt    <= `SMS_BIT_ZERO;
			shiftFull <= `SMS_FLAG_RST;
			sampleBit <= `SMS_FLAG_RST;
			sckPrev   <= `SMS_FLAG_RST;
			shiftReg  <= `SMS_BYTE_RST;
		end
		else
		begin
			state    <= next_state;
			sckPrev  <= sckS;
			shiftReg <= next_shift;
			if (masterRise || slaveRise)
				sampleBit <= masterRole ? misoS : mosiS;
			if (!serialEnable || faultEvent)
				bitCnt <= `SMS_BIT_ZERO;
			else if (shiftNow)
				bitCnt <= bitCnt + 3'h1;
			if (!serialEnable)
				shiftFull <= `SMS_FLAG_RST;
			else if (loadShift)
				shiftFull <= 1'b1;
			else if (byteDone)
				shiftFull <= `SMS_FLAG_RST;
		end
	end

	// Master bit: a fault drops it and only a software write restores it
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			masterRole <= `SMS_MASTER_RST;
		else if (faultEvent)
			masterRole <= 1'b0;
		else if (ctrlWrite)
			masterRole <= ctrlMasterIn;
	end

	// Flags: a hardware set in the same cycle as a clear always wins
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			modeFault     <= `SMS_FLAG_RST;
			faultArmed    <= `SMS_FLAG_RST;
			transferDone  <= `SMS_FLAG_RST;
			txBufferEmpty <= `SMS_TXE_RST;
			rxData        <= `SMS_BYTE_RST;
		end
		else
		begin
			if (faultEvent)
				modeFault <= 1'b1;
			else if (faultArmed && ctrlWrite)
				modeFault <= `SMS_FLAG_RST;
			if (statusRead && modeFault)
				faultArmed <= 1'b1;
			else if (ctrlWrite)
				faultArmed <= `SMS_FLAG_RST;
			if (byteDone)
			begin
				transferDone <= 1'b1;
				rxData       <= {shiftReg[`SMS_DATA_W-2:0], sampleBit};
			end
			else if (doneClear)
				transferDone <= `SMS_FLAG_RST;
			if (loadShift)
				txBufferEmpty <= 1'b1;
			else if (txWrite || txEmptyClear)
				txBufferEmpty <= `SMS_FLAG_RST;
		end
	end

	assign irq = intEnable && (transferDone || modeFault
		|| (txBufferEmpty && enhancedMode));

	// Pin override; open-drain only ever pulls low, the pull-up does the rest
	assign sckOut    = serialEnable ? (state == sms_pkg::SMS_HIGH) : portSck.out;
	assign sckOe     = serialEnable ? (masterRole && drivesPins && !(openDrain && sckOut))
		: portSck.oe;
	assign mosiOut   = serialEnable ? shiftReg[`SMS_DATA_W-1] : portMosi.out;
	assign mosiOe    = serialEnable ? (masterRole && busy && drivesPins && !(openDrain && mosiOut))
		: portMosi.oe;
	assign misoOut   = serialEnable ? shiftReg[`SMS_DATA_W-1] : portMiso.out;
	assign misoOe    = serialEnable ? (!masterRole && selected && drivesPins
		&& !(openDrain && misoOut)) : portMiso.oe;
	// The select pin is never driven by the engine, so it stays ordinary I/O
	assign selectOut = portSelect.out;
	assign selectOe  = portSelect.oe;

	// Helper: clock highs since the byte was loaded
	logic [3:0] riseCnt;
	always_ff @(posedge sys_clk)
	begin
		if (reset || loadShift)
			riseCnt <= 4'h0;
		else if (masterRise)
			riseCnt <= riseCnt + 4'h1;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence seq_fault_cond;
		faultEvent;
	endsequence

	sequence seq_fault_effect;
		!masterRole && modeFault ##1 !busy;
	endsequence

	chk_fault_drops_master: assert property (seq_fault_cond |=> seq_fault_effect)
		else $error("mode fault did not drop master role");
	chk_fault_irq_raise: assert property (faultEvent && intEnable |=> irq)
		else $error("mode fault did not request interrupt");
	chk_fault_flag_keep: assert property
		(modeFault && !(faultArmed && ctrlWrite) |=> modeFault)
		else $error("mode fault flag cleared without read then write");
	chk_master_stays_off: assert property
		(!masterRole && !(ctrlWrite && ctrlMasterIn) |=> !masterRole)
		else $error("master role restored by hardware");
	chk_ignore_keeps_master: assert property
		(masterRole && selectIgnore && !ctrlWrite |=> masterRole)
		else $error("select ignored yet master role lost");
	chk_miso_hiz_unselected: assert property (serialEnable && !selected |-> !misoOe)
		else $error("unselected slave drives data-in line");
	chk_mosi_idle_release: assert property (serialEnable && !busy |-> !mosiOe)
		else $error("data-out driven between transfers");
	chk_txe_on_load: assert property (loadShift |=> txBufferEmpty && shiftFull)
		else $error("load did not set empty flag");
	chk_txe_write_clear: assert property (txWrite && !loadShift |=> !txBufferEmpty)
		else $error("data write did not clear empty flag");
	chk_done_capture: assert property
		(byteDone |=> transferDone && rxData == $past(next_shift))
		else $error("byte end did not set done or capture byte");
	chk_eight_clocks: assert property
		(byteDone && masterRole |-> riseCnt == `SMS_BYTE_CLOCKS)
		else $error("master byte did not have eight clocks");
	chk_txe_irq_gate: assert property (irq && !transferDone && !modeFault |-> enhancedMode)
		else $error("empty interrupt without enhanced mode");
	chk_disabled_pass: assert property
		(!serialEnable |-> sckOe == portSck.oe && mosiOe == portMosi.oe)
		else $error("pins overridden while disabled");
endmodule // sms_master_select

// *** verification/sms_slave_model.sv ***
// Behavioural serial slave standing on the far side of the master link.
// Assumes mode 0 framing: sample data-in on clock rise, shift on fall, MSB first.
`timescale 1ns/100ps

module sms_slave_model (
	input  wire logic       sck,       // Serial clock from the master
	input  wire logic       mosi,      // Data from the master
	input  wire logic       selN,      // Select, active low
	output logic            miso,      // Data to the master, pulled high when released
	output logic      [7:0] shiftReg,  // Echo register, holds last byte received
	output int              riseCount  // Clock rises seen so far
);
	logic sampled;
	initial shiftReg = 8'hA5;
	initial riseCount = 0;
	// Echo loop: each byte sent back is the byte received before it
	// Only a selected slave counts and samples; edges while select is high are ignored
	always @(posedge sck)
		if (!selN)
		begin
			sampled = mosi;
			riseCount = riseCount + 1;
		end
	always @(negedge sck)
		if (!selN)
			shiftReg = {shiftReg[6:0], sampled};
	// Released line floats to the pull-up level, never holds the last bit
	assign miso = selN ? 1'b1 : shiftReg[7];
endmodule // sms_slave_model

// *** verification/tb_top.sv ***
// Self-checking bench for the serial master select-control block.
// Assumes the design sources are compiled first; drives a 100 MHz clock.
`timescale 1ns/100ps

module tb_top;
	logic sys_clk = 1'b0, reset = 1'b1, serialEnable = 1'b1, ctrlWrite = 1'b0;
	logic ctrlMasterIn = 1'b0, selectDisable = 1'b1, selectIgnore = 1'b0, clockPhase = 1'b0;
	logic intEnable = 1'b0, enhancedMode = 1'b0, statusRead = 1'b0, txEmptyClear = 1'b0;
	logic doneClear = 1'b0, txValid = 1'b0, extSelN = 1'b1;
	logic [7:0] txData = 8'h00;
	sms_pkg::sms_port_mode_t portMode = sms_pkg::SMS_PUSH_PULL;
	sms_pkg::sms_pin_t portSck = '0, portMosi = '0, portMiso = '0, portSelect = 2'h2;
	logic txReady, masterRole, modeFault, transferDone, txBufferEmpty, irq;
	logic [7:0] rxData, slaveByte, prevByte;
	logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, selectOut, selectOe;
	logic slaveMiso, seenRise, prevDone;
	logic [15:0] expQ[$];
	logic [15:0] e;
	int numErrors = 0, numChecks = 0, cycles = 0, riseCount, lastCount = 0;
	logic [31:0] rngState = 32'h2393;
	// Wire levels resolved from every party's enable; pull-ups where released
	wire sckIn = sckOe ? sckOut : 1'b1;
	wire mosiIn = mosiOe ? mosiOut : 1'b1;
	wire misoIn = misoOe ? misoOut : slaveMiso;
	wire selectInN = selectOe ? selectOut : extSelN;

	always #5 sys_clk = ~sys_clk;

	// Half bit of 40 ns gives the 80 ns link clock
	sms_master_select #(.HALF_BIT_NS(40)) dut (
		.sys_clk, .reset, .serialEnable, .ctrlWrite, .ctrlMasterIn, .selectDisable,
		.selectIgnore, .clockPhase, .intEnable, .enhancedMode, .portMode, .statusRead,
		.txEmptyClear, .doneClear, .txValid, .txReady, .txData, .masterRole, .modeFault,
		.transferDone, .txBufferEmpty, .rxData, .irq, .portSck, .portMosi, .portMiso,
		.portSelect, .sckIn, .sckOut, .sckOe, .mosiIn, .mosiOut, .mosiOe, .misoIn,
		.misoOut, .misoOe, .selectInN, .selectOut, .selectOe
	);

	// Device select pin doubles as the one slave's select, so only one slave is ever chosen
	sms_slave_model partner (.sck(sckIn), .mosi(mosiIn), .selN(selectInN),
		.miso(slaveMiso), .shiftReg(slaveByte), .riseCount(riseCount));

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic giveVerdict();
		$display("checks=%0d errors=%0d", numChecks, numErrors);
		if (numErrors == 0 && numChecks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic ctrlWr(input logic m);
		@(posedge sys_clk);
		ctrlMasterIn <= m;
		ctrlWrite <= 1'b1;
		@(posedge sys_clk);
		ctrlWrite <= 1'b0;
	endtask

	// Queue the expected echo and byte, then hold the write until it is taken
	task automatic sendByte(input logic [7:0] v);
		logic ok;
		expQ.push_back({prevByte, v});
		prevByte = v;
		@(posedge sys_clk);
		txValid <= 1'b1;
		txData <= v;
		forever
		begin
			@(negedge sys_clk);
			ok = txReady;
			@(posedge sys_clk);
			if (ok === 1'b1)
				break;
		end
		txValid <= 1'b0;
	endtask

	task automatic waitDone();
		@(negedge sys_clk);
		while (transferDone !== 1'b1)
			@(negedge sys_clk);
		@(posedge sys_clk);
		doneClear <= 1'b1;
		@(posedge sys_clk);
		doneClear <= 1'b0;
	endtask

	// Result watcher: one note consumed per finished byte
	always @(negedge sys_clk)
	begin
		if (seenRise)
		begin
			e = expQ.pop_front();
			check(rxData, e[15:8]);
			check(slaveByte, e[7:0]);
			check(riseCount - lastCount, 8);
			lastCount = riseCount;
		end
		seenRise = (transferDone === 1'b1) && (prevDone !== 1'b1);
		prevDone = transferDone;
	end

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			numErrors++;
			giveVerdict();
		end
	end

	initial
	begin
		prevByte = 8'hA5;
		seenRise = 1'b0;
		tick(4);
		reset <= 1'b0;
		@(negedge sys_clk);
		check(masterRole, 1'b0);
		check(txBufferEmpty, 1'b1);
		check({modeFault, transferDone}, 2'h0);
		ctrlWr(1'b1);
		tick(1);
		// Select pin as a plain output picks the slave; the master ignores it
		portSelect <= 2'h1;
		tick(3);
		@(negedge sys_clk);
		check(masterRole, 1'b1);
		check({selectOut, selectOe}, 2'h1);
		check(sckOe, 1'b1);
		check(mosiOe, 1'b0);
		rngState = xorshift(rngState);
		sendByte(rngState[7:0]);
		@(negedge sys_clk);
		check(txBufferEmpty, 1'b0);
		tick(3);
		@(negedge sys_clk);
		check(txBufferEmpty, 1'b1);
		tick(10);
		@(negedge sys_clk);
		check(mosiOe, 1'b1);
		waitDone();
		tick(3);
		@(negedge sys_clk);
		check(mosiOe, 1'b0);
		// Select frames each burst rather than staying low throughout
		@(posedge sys_clk);
		portSelect <= 2'h2;
		tick(1);
		portSelect <= 2'h1;
		// Fill the buffer until it refuses, then drain back to back
		for (int i = 0; i < 5; i++)
		begin
			rngState = xorshift(rngState);
			sendByte(rngState[7:0]);
		end
		@(negedge sys_clk);
		check(txReady, 1'b0);
		for (int i = 0; i < 5; i++)
			waitDone();
		tick(3);
		intEnable <= 1'b1;
		tick(2);
		@(negedge sys_clk);
		check(irq, 1'b0);
		@(posedge sys_clk);
		enhancedMode <= 1'b1;
		tick(1);
		@(negedge sys_clk);
		check(irq, 1'b1);
		@(posedge sys_clk);
		txEmptyClear <= 1'b1;
		tick(1);
		txEmptyClear <= 1'b0;
		enhancedMode <= 1'b0;
		tick(1);
		@(negedge sys_clk);
		check({txBufferEmpty, irq}, 2'h0);
		// Competing master pulls select low; release the pin first so no stale low is seen
		@(posedge sys_clk);
		portSelect <= 2'h2;
		tick(3);
		selectDisable <= 1'b0;
		tick(4);
		@(negedge sys_clk);
		check(masterRole, 1'b1);
		@(posedge sys_clk);
		extSelN <= 1'b0;
		tick(6);
		@(negedge sys_clk);
		check({masterRole, sckOe, mosiOe}, 3'h0);
		check({modeFault, irq}, 2'h3);
		check(misoOe, 1'b1);
		@(posedge sys_clk);
		extSelN <= 1'b1;
		selectDisable <= 1'b1;
		tick(5);
		@(negedge sys_clk);
		check(misoOe, 1'b0);
		check(masterRole, 1'b0);
		@(posedge sys_clk);
		selectDisable <= 1'b0;
		tick(2);
		@(negedge sys_clk);
		check(modeFault, 1'b1);
		ctrlWr(1'b0);
		tick(1);
		@(negedge sys_clk);
		check(modeFault, 1'b1);
		@(posedge sys_clk);
		statusRead <= 1'b1;
		tick(1);
		statusRead <= 1'b0;
		ctrlWr(1'b0);
		tick(1);
		@(negedge sys_clk);
		check(modeFault, 1'b0);
		@(posedge sys_clk);
		clockPhase <= 1'b1;
		selectDisable <= 1'b1;
		tick(4);
		@(negedge sys_clk);
		check(misoOe, 1'b1);
		@(posedge sys_clk);
		clockPhase <= 1'b0;
		selectIgnore <= 1'b1;
		selectDisable <= 1'b0;
		ctrlWr(1'b1);
		extSelN <= 1'b0;
		tick(6);
		@(negedge sys_clk);
		check({masterRole, modeFault}, 2'h2);
		@(posedge sys_clk);
		selectIgnore <= 1'b0;
		selectDisable <= 1'b1;
		tick(6);
		@(negedge sys_clk);
		check({masterRole, modeFault}, 2'h2);
		@(posedge sys_clk);
		portMode <= sms_pkg::SMS_INPUT_ONLY;
		tick(2);
		@(negedge sys_clk);
		check(sckOe, 1'b0);
		// Open drain: idle clock low is pulled down, idle data-out left to the pull-up
		@(posedge sys_clk);
		portMode <= sms_pkg::SMS_OPEN_DRAIN;
		tick(2);
		@(negedge sys_clk);
		check({sckOut, sckOe, mosiOe}, 3'h2);
		@(posedge sys_clk);
		portMode <= sms_pkg::SMS_PUSH_PULL;
		serialEnable <= 1'b0;
		portSck <= 2'h3;
		portMosi <= 2'h1;
		portMiso <= 2'h2;
		tick(2);
		@(negedge sys_clk);
		check({sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe}, 6'h36);
		giveVerdict();
	end
endmodule // tb_top
